// ==== cpc_chk_properties.sv ====
/* Port checker of cpc_corner_pll.
 * Assumes it is bound by name to the ports of that module. */
`timescale 1ns/100ps
module cpc_chk (
    input wire logic        core_clk,
    input wire logic        reset_n,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        pin_ctrl_sel,
    input wire logic [1:0]  pin_op_mode,
    input wire logic [1:0]  pin_fb_mode,
    input wire logic [1:0]  pin_fb_out_sel,
    input wire logic [3:0]  pin_ref_sel,
    input wire logic [5:0]  pin_ref_div,
    input wire logic [5:0]  ref_buf_in,
    input wire logic        fb_ext_in,
    input wire logic [3:0]  pll_out,
    input wire logic        fb_tap,
    input wire logic        pfd_fb_clk,
    input wire logic        pll_lock,
    input wire logic        cfg_err
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside read slot");
    a_lock_cfg: assert property (cfg_err |=> !pll_lock)
        else $error("lock high with illegal setting");
    a_lock_mode: assert property (pin_ctrl_sel && pin_op_mode != 2'h0
        |-> ##2 !pll_lock) else $error("lock high outside normal mode");
    a_lock_change: assert property (pin_ctrl_sel && $past(pin_ctrl_sel)
        && pin_ref_div != $past(pin_ref_div) |-> ##2 !pll_lock)
        else $error("lock held over divider change");
    a_out_reset: assert property ((pin_ctrl_sel
        && pin_op_mode == 2'h3)[*3] |-> pll_out == 4'h0)
        else $error("outputs active in reset mode");
    a_bypass_out: assert property ((pin_ctrl_sel && pin_op_mode == 2'h1
        && pin_ref_sel == 4'h0)[*3] |-> pll_out[0] == $past(ref_buf_in[0]))
        else $error("bypass output not following reference");
    a_tap_copy: assert property ((pin_ctrl_sel
        && pin_fb_out_sel == 2'h0)[*2] |-> fb_tap == $past(pll_out[0]))
        else $error("feedback tap wrong");
    a_ext_fb: assert property ((pin_ctrl_sel && pin_fb_mode == 2'h1
        && !pin_op_mode[1])[*2] |-> pfd_fb_clk == $past(fb_ext_in))
        else $error("external path wrong");
endmodule

bind cpc_corner_pll cpc_chk chk (.*);

// ==== cpc_consts.svh ====
/*
 * Constants of the corner clock generator PLL controller: register word
 * addresses, field positions, reset values and divider limits.
 * Assumes it is included by bare name wherever a figure is needed.
 */
`ifndef CPC_CONSTS_SVH
`define CPC_CONSTS_SVH

`define CPC_ADDR_CTRL       8'h00
`define CPC_ADDR_REF        8'h01
`define CPC_ADDR_FB         8'h02
`define CPC_ADDR_OUT0       8'h04
`define CPC_ADDR_STATUS     8'h08
`define CPC_ADDR_MUX_BASE   8'h40
`define CPC_ADDR_HUB_BASE   8'h80
`define CPC_MUX_ENTRIES     8'h40
`define CPC_HUB_ENTRIES     8'h30

`define CPC_CTRL_MODE_LSB   0
`define CPC_CTRL_FBM_LSB    2
`define CPC_CTRL_FRAC_BIT   4
`define CPC_CTRL_DIV2_BIT   5
`define CPC_CTRL_PRST_BIT   6
`define CPC_CTRL_FBSEL_LSB  7
`define CPC_REF_SEL_LSB     0
`define CPC_REF_DIV_LSB     8
`define CPC_FB_Q_LSB        0
`define CPC_FB_F_LSB        16
`define CPC_OUT_N_LSB       0
`define CPC_OUT_PH_LSB      8
`define CPC_OUT_BYP_BIT     12
`define CPC_ST_PINS_BIT     2
`define CPC_ST_PH_LSB       8

`define CPC_CTRL_RESET      9'h003
`define CPC_REF_RESET       10'h040
`define CPC_FB_RESET        24'h000002
`define CPC_OUT_RESET       10'h001

`define CPC_REF_BUFS        4'h6
`define CPC_REF_SRCS        4'hA
`define CPC_Q_MIN_INT       8'h02
`define CPC_Q_MIN_FRAC      8'h08
`define CPC_Q_MAX_FRAC      8'hFE
`define CPC_HUB_SRCS        7'h50
`define CPC_PHASES          3'h7

`endif

// ==== cpc_corner_pll.sv ====
/*
 * Digital model of one corner clock generator PLL with its four output
 * rotators, plus the top and bottom clock muxes and the central hub.
 * Assumes all inputs, including reference and returned feedback clocks,
 * are sampled levels synchronous to core_clk. One VCO period is eight
 * core_clk cycles (sixteen with the divide-by-two stage), one per phase.
 */
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/100ps
`include "cpc_consts.svh"

module cpc_corner_pll #(
    parameter int LOCK_INT_REFS  = 500,
    parameter int LOCK_FRAC_REFS = 1000
) (
    input  wire logic         core_clk,
    input  wire logic         reset_n,
    input  wire logic [7:0]   reg_addr,
    input  wire logic [31:0]  reg_wdata,
    input  wire logic         reg_wr,
    input  wire logic         reg_rd,
    output logic      [31:0]  reg_rdata,
    input  wire logic         pin_ctrl_sel,
    input  wire logic [1:0]   pin_op_mode,
    input  wire logic [1:0]   pin_fb_mode,
    input  wire logic         pin_frac_en,
    input  wire logic         pin_div2,
    input  wire logic         pin_phase_reset,
    input  wire logic [1:0]   pin_fb_out_sel,
    input  wire logic [3:0]   pin_ref_sel,
    input  wire logic [5:0]   pin_ref_div,
    input  wire logic [7:0]   pin_fb_div,
    input  wire logic [15:0]  pin_frac,
    input  wire logic [23:0]  pin_out_div,
    input  wire logic [11:0]  pin_out_phase,
    input  wire logic [3:0]   pin_out_bypass,
    input  wire logic [5:0]   ref_buf_in,
    input  wire logic [3:0]   prev_pll_out,
    input  wire logic         fb_ext_in,
    input  wire logic [127:0] top_src,
    input  wire logic [127:0] bot_src,
    input  wire logic [15:0]  fabric_clk_data,
    output logic      [3:0]   pll_out,
    output logic              fb_tap,
    output logic              ref_div_clk,
    output logic              pfd_fb_clk,
    output logic              pll_lock,
    output logic              cfg_err,
    output logic      [31:0]  top_bus,
    output logic      [31:0]  bot_bus,
    output logic      [47:0]  global_bus
);

    generate
        if (LOCK_INT_REFS < 1 || LOCK_INT_REFS > 2047 ||
            LOCK_FRAC_REFS < 1 || LOCK_FRAC_REFS > 2047)
        begin : g_bad_lock
            $error("cpc_corner_pll: lock counts must be 1 to 2047");
        end
    endgenerate

    // Register file
    logic [8:0]  ctrl_reg;
    logic [9:0]  ref_reg;
    logic [23:0] fb_reg;
    logic [9:0]  out_reg     [4];
    logic [6:0]  mux_sel_reg [64];
    logic [6:0]  hub_sel_reg [48];
    logic        prst_reg;
    logic        pin_prst_reg;

    wire [7:0] mux_idx  = reg_addr - `CPC_ADDR_MUX_BASE;
    wire [7:0] hub_idx  = reg_addr - `CPC_ADDR_HUB_BASE;
    wire [7:0] out_idx  = reg_addr - `CPC_ADDR_OUT0;
    wire       hit_ctrl = reg_addr == `CPC_ADDR_CTRL;
    wire       hit_ref  = reg_addr == `CPC_ADDR_REF;
    wire       hit_fb   = reg_addr == `CPC_ADDR_FB;
    wire       hit_out  = out_idx < 8'h04;
    wire       hit_st   = reg_addr == `CPC_ADDR_STATUS;
    wire       hit_mux  = mux_idx < `CPC_MUX_ENTRIES;
    wire       hit_hub  = hub_idx < `CPC_HUB_ENTRIES;

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_reg <= `CPC_CTRL_RESET;
            ref_reg  <= `CPC_REF_RESET;
            fb_reg   <= `CPC_FB_RESET;
        end
        else if (reg_wr)
        begin
            if (hit_ctrl)
                ctrl_reg <= reg_wdata[8:0];
            if (hit_ref)
                ref_reg <= {reg_wdata[13:8], reg_wdata[3:0]};
            if (hit_fb)
                fb_reg <= {reg_wdata[31:16], reg_wdata[7:0]};
        end
    end

    // Register write of the phase-reset bit and a rising pin both pulse
    wire prst_pin_rise = pin_ctrl_sel & pin_phase_reset & ~pin_prst_reg;
    wire prst_wr       = reg_wr & hit_ctrl & ~pin_ctrl_sel &
                         reg_wdata[`CPC_CTRL_PRST_BIT];

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prst_reg     <= 1'b0;
            pin_prst_reg <= 1'b0;
        end
        else
        begin
            prst_reg     <= prst_wr | prst_pin_rise;
            pin_prst_reg <= pin_phase_reset;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 64; gi++)
        begin : g_mux_regs
            always_ff @(posedge core_clk or negedge reset_n)
            begin
                if (!reset_n)
                    mux_sel_reg[gi] <= 7'h00;
                else if (reg_wr && hit_mux && mux_idx[5:0] == gi)
                    mux_sel_reg[gi] <= reg_wdata[6:0];
            end
        end
        for (gi = 0; gi < 48; gi++)
        begin : g_hub_regs
            always_ff @(posedge core_clk or negedge reset_n)
            begin
                if (!reset_n)
                    hub_sel_reg[gi] <= 7'h00;
                else if (reg_wr && hit_hub && hub_idx[5:0] == gi)
                    hub_sel_reg[gi] <= reg_wdata[6:0];
            end
        end
        for (gi = 0; gi < 4; gi++)
        begin : g_out_regs
            always_ff @(posedge core_clk or negedge reset_n)
            begin
                if (!reset_n)
                    out_reg[gi] <= `CPC_OUT_RESET;
                else if (reg_wr && hit_out && out_idx[1:0] == gi)
                    out_reg[gi] <= {reg_wdata[`CPC_OUT_BYP_BIT],
                                    reg_wdata[10:8], reg_wdata[5:0]};
            end
        end
    endgenerate

    // Effective settings: direct pins or registers
    wire [1:0]  eff_mode   = pin_ctrl_sel ? pin_op_mode : ctrl_reg[1:0];
    wire [1:0]  eff_fbm    = pin_ctrl_sel ? pin_fb_mode : ctrl_reg[3:2];
    wire        eff_frac   = pin_ctrl_sel ? pin_frac_en :
                             ctrl_reg[`CPC_CTRL_FRAC_BIT];
    wire        eff_div2   = pin_ctrl_sel ? pin_div2 :
                             ctrl_reg[`CPC_CTRL_DIV2_BIT];
    wire [1:0]  eff_fbsel  = pin_ctrl_sel ? pin_fb_out_sel : ctrl_reg[8:7];
    wire [3:0]  eff_refsel = pin_ctrl_sel ? pin_ref_sel : ref_reg[3:0];
    wire [5:0]  eff_m      = pin_ctrl_sel ? pin_ref_div : ref_reg[9:4];
    wire [7:0]  eff_q      = pin_ctrl_sel ? pin_fb_div : fb_reg[7:0];
    wire [15:0] eff_f      = pin_ctrl_sel ? pin_frac : fb_reg[23:8];
    wire [5:0]  eff_n      [4];
    wire [2:0]  eff_ph     [4];
    wire [3:0]  eff_byp;

    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_eff_out
            assign eff_n[gi]   = pin_ctrl_sel ? pin_out_div[gi*6 +: 6] :
                                 out_reg[gi][5:0];
            assign eff_ph[gi]  = pin_ctrl_sel ? pin_out_phase[gi*3 +: 3] :
                                 out_reg[gi][8:6];
            assign eff_byp[gi] = pin_ctrl_sel ? pin_out_bypass[gi] :
                                 out_reg[gi][9];
        end
    endgenerate

    wire run_osc  = eff_mode == cpc_pkg::CPC_OP_NORMAL ||
                    eff_mode == cpc_pkg::CPC_OP_BYPASS;
    wire mode_byp = eff_mode == cpc_pkg::CPC_OP_BYPASS;
    wire is_int   = eff_fbm == cpc_pkg::CPC_FB_INTERNAL;
    wire is_ext   = eff_fbm == cpc_pkg::CPC_FB_EXTERNAL;

    // Ranges the block can serve; anything else is flagged and blocks lock
    wire n_zero   = eff_n[0] == 6'h00 || eff_n[1] == 6'h00 ||
                    eff_n[2] == 6'h00 || eff_n[3] == 6'h00;
    wire q_bad    = eff_frac ? (eff_q < `CPC_Q_MIN_FRAC ||
                                eff_q > `CPC_Q_MAX_FRAC)
                             : eff_q < `CPC_Q_MIN_INT;
    wire cfg_bad  = eff_m == 6'h00 || n_zero || q_bad ||
                    eff_fbm == cpc_pkg::CPC_FB_UNUSED ||
                    (eff_frac && !is_int) ||
                    eff_refsel >= `CPC_REF_SRCS;

    // Reference source: six buffers, then four outputs of previous PLL
    wire [9:0] ref_pool = {prev_pll_out, ref_buf_in};
    wire       ref_raw  = eff_refsel < `CPC_REF_SRCS ?
                          ref_pool[eff_refsel] : 1'b0;

    // Reference divider: toggles every M edges of either polarity
    logic       ref_q_reg;
    logic [5:0] ref_cnt_reg;
    logic       ref_div_reg;
    wire        ref_edge = ref_raw != ref_q_reg;
    wire        ref_wrap = ref_cnt_reg >= eff_m - 6'h01;

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ref_q_reg   <= 1'b0;
            ref_cnt_reg <= 6'h00;
            ref_div_reg <= 1'b0;
        end
        else
        begin
            ref_q_reg <= ref_raw;
            if (!run_osc)
            begin
                ref_cnt_reg <= 6'h00;
                ref_div_reg <= 1'b0;
            end
            else if (ref_edge)
            begin
                ref_cnt_reg <= ref_wrap ? 6'h00 : ref_cnt_reg + 6'h01;
                if (ref_wrap)
                    ref_div_reg <= ~ref_div_reg;
            end
        end
    end

    // Oscillator model: one phase per tick, optional halving
    logic       half_reg;
    logic [2:0] vco_ph_reg;
    wire        vco_tick = run_osc & (~eff_div2 | half_reg);

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            half_reg   <= 1'b0;
            vco_ph_reg <= 3'h0;
        end
        else
        begin
            half_reg <= ~half_reg;
            if (vco_tick)
                vco_ph_reg <= vco_ph_reg + 3'h1;
        end
    end

    // Output rotators and dividers
    logic [8:0] pos_reg [4];
    logic [2:0] cur_reg [4];
    logic [3:0] out_q_reg;

    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_rot
            wire [8:0] last = {eff_n[gi], 3'h0} - 9'h001;
            wire [8:0] half = {1'b0, eff_n[gi], 2'h0};
            wire       hold = cur_reg[gi] != eff_ph[gi];

            always_ff @(posedge core_clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    pos_reg[gi] <= 9'h000;
                    cur_reg[gi] <= 3'h0;
                end
                else if (prst_reg)
                begin
                    pos_reg[gi] <= 9'h000;
                    cur_reg[gi] <= 3'h0;
                end
                else if (vco_tick)
                begin
                    if (pos_reg[gi] >= last)
                    begin
                        // Stretch the low half by one phase per step
                        if (hold)
                            cur_reg[gi] <= cur_reg[gi] + 3'h1;
                        else
                            pos_reg[gi] <= 9'h000;
                    end
                    else
                        pos_reg[gi] <= pos_reg[gi] + 9'h001;
                end
            end

            always_ff @(posedge core_clk or negedge reset_n)
            begin
                if (!reset_n)
                    out_q_reg[gi] <= 1'b0;
                // Power-down and reset silence bypassed outputs as well
                else if ((eff_byp[gi] || mode_byp) && run_osc)
                    out_q_reg[gi] <= ref_raw;
                else
                    out_q_reg[gi] <= run_osc & (pos_reg[gi] < half);
            end
        end
    endgenerate

    // Feedback path
    logic        fb_tap_reg;
    logic        fb_q_reg;
    logic [8:0]  fb_cnt_reg;
    logic        pfd_reg;
    logic        ext_reg;
    logic [15:0] acc_reg;
    wire         fb_src   = is_int ? vco_ph_reg[2] : fb_ext_in;
    wire         fb_edge  = fb_src != fb_q_reg;
    wire [8:0]   fb_limit = {1'b0, eff_q} + {8'h00, ext_reg} - 9'h001;
    wire         fb_wrap  = fb_cnt_reg >= fb_limit;
    wire [16:0]  acc_sum  = {1'b0, acc_reg} + {1'b0, eff_f};

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            fb_tap_reg <= 1'b0;
        else
            fb_tap_reg <= out_q_reg[eff_fbsel];
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            fb_q_reg   <= 1'b0;
            fb_cnt_reg <= 9'h000;
            pfd_reg    <= 1'b0;
            ext_reg    <= 1'b0;
            acc_reg    <= 16'h0000;
        end
        else
        begin
            fb_q_reg <= fb_src;
            if (!run_osc)
            begin
                fb_cnt_reg <= 9'h000;
                pfd_reg    <= 1'b0;
                ext_reg    <= 1'b0;
            end
            else if (is_ext)
                pfd_reg <= fb_ext_in;
            else if (fb_edge)
            begin
                fb_cnt_reg <= fb_wrap ? 9'h000 : fb_cnt_reg + 9'h001;
                if (fb_wrap)
                begin
                    pfd_reg <= ~pfd_reg;
                    if (!pfd_reg)
                    begin
                        acc_reg <= eff_frac ? acc_sum[15:0] : 16'h0000;
                        ext_reg <= eff_frac & acc_sum[16];
                    end
                    else
                        ext_reg <= 1'b0;
                end
            end
        end
    end

    // Lock: counted in divided reference periods after a stable setup
    logic [49:0]  cfg_q_reg;
    logic [5:0]   cfg_q_n2;
    logic [5:0]   cfg_q_n3;
    logic [10:0]  lock_cnt_reg;
    logic         lock_reg;
    logic         err_reg;
    logic         ref_div_q_reg;
    wire  [49:0]  cfg_now  = {eff_m, eff_q, eff_f, eff_frac, eff_div2,
                              eff_fbm, eff_refsel, eff_n[0], eff_n[1]};
    wire          cfg_chg  = cfg_now != cfg_q_reg ||
                             eff_n[2] != cfg_q_n2 || eff_n[3] != cfg_q_n3;
    wire  [10:0]  lock_lim = eff_frac ? 11'(LOCK_FRAC_REFS - 1)
                                      : 11'(LOCK_INT_REFS - 1);
    wire          ref_rise = ref_div_reg & ~ref_div_q_reg;
    wire          lock_hold = eff_mode != cpc_pkg::CPC_OP_NORMAL ||
                              cfg_chg || cfg_bad;

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cfg_q_reg     <= 50'h0;
            cfg_q_n2      <= 6'h00;
            cfg_q_n3      <= 6'h00;
            lock_cnt_reg  <= 11'h000;
            lock_reg      <= 1'b0;
            err_reg       <= 1'b0;
            ref_div_q_reg <= 1'b0;
        end
        else
        begin
            cfg_q_reg     <= cfg_now;
            cfg_q_n2      <= eff_n[2];
            cfg_q_n3      <= eff_n[3];
            err_reg       <= cfg_bad;
            ref_div_q_reg <= ref_div_reg;
            if (lock_hold)
            begin
                lock_cnt_reg <= 11'h000;
                lock_reg     <= 1'b0;
            end
            else if (ref_rise && !lock_reg)
            begin
                if (lock_cnt_reg >= lock_lim)
                    lock_reg <= 1'b1;
                else
                    lock_cnt_reg <= lock_cnt_reg + 11'h001;
            end
        end
    end

    // Clock muxes and hub
    logic [31:0] top_reg;
    logic [31:0] bot_reg;
    logic [47:0] hub_reg;
    wire  [79:0] hub_pool = {fabric_clk_data, bot_reg, top_reg};

    generate
        for (gi = 0; gi < 32; gi++)
        begin : g_mux
            always_ff @(posedge core_clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    top_reg[gi] <= 1'b0;
                    bot_reg[gi] <= 1'b0;
                end
                else
                begin
                    top_reg[gi] <= top_src[mux_sel_reg[gi]];
                    bot_reg[gi] <= bot_src[mux_sel_reg[gi + 32]];
                end
            end
        end
        for (gi = 0; gi < 48; gi++)
        begin : g_hub
            wire [6:0] s = hub_sel_reg[gi];
            always_ff @(posedge core_clk or negedge reset_n)
            begin
                if (!reset_n)
                    hub_reg[gi] <= 1'b0;
                else
                    hub_reg[gi] <= s < `CPC_HUB_SRCS ? hub_pool[s] : 1'b0;
            end
        end
    endgenerate

    // Read path, data valid one cycle after the strobe
    logic [31:0] rdata_reg;
    wire  [31:0] rd_out    = {19'h0, out_reg[out_idx[1:0]][9],
                              1'b0, out_reg[out_idx[1:0]][8:6],
                              2'h0, out_reg[out_idx[1:0]][5:0]};
    wire  [31:0] rd_status = {12'h0, cur_reg[3], cur_reg[2], cur_reg[1],
                              cur_reg[0], 5'h0, pin_ctrl_sel,
                              err_reg, lock_reg};
    wire  [31:0] rd_mux    = {25'h0, mux_sel_reg[mux_idx[5:0]]};
    wire  [31:0] rd_hub    = {25'h0, hub_sel_reg[hub_idx[5:0]]};
    wire  [31:0] rdata_next =
        hit_ctrl ? {23'h0, ctrl_reg[8:7], 1'b0, ctrl_reg[5:0]} :
        hit_ref  ? {18'h0, ref_reg[9:4], 4'h0, ref_reg[3:0]} :
        hit_fb   ? {fb_reg[23:8], 8'h00, fb_reg[7:0]} :
        hit_out  ? rd_out :
        hit_st   ? rd_status :
        hit_mux  ? rd_mux :
        hit_hub  ? rd_hub : 32'h0000_0000;

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            rdata_reg <= 32'h0000_0000;
        else
            rdata_reg <= reg_rd ? rdata_next : 32'h0000_0000;
    end

    assign reg_rdata   = rdata_reg;
    assign pll_out     = out_q_reg;
    assign fb_tap      = fb_tap_reg;
    assign ref_div_clk = ref_div_reg;
    assign pfd_fb_clk  = pfd_reg;
    assign pll_lock    = lock_reg;
    assign cfg_err     = err_reg;
    assign top_bus     = top_reg;
    assign bot_bus     = bot_reg;
    assign global_bus  = hub_reg;

endmodule

// ==== cpc_fabric_model.sv ====
/* Fabric-side partner: clocks on the buffers and the previous PLL, and
 * the tap returned through a tree delay. Assumes one clock domain. */
`timescale 1ns/100ps
module cpc_fabric_model #(
    parameter int TREE = 2
) (
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    input  wire logic       fb_tap,
    output logic      [5:0] ref_buf_in,
    output logic      [3:0] prev_pll_out,
    output logic            fb_ext_in
);
    logic [7:0] cnt_reg;
    logic [7:0] tree_reg;

    // Buffer k toggles every 2^k cycles
    assign ref_buf_in = cnt_reg[5:0];
    assign prev_pll_out = cnt_reg[7:4];
    // Tree returns the tap TREE cycles later
    assign fb_ext_in = tree_reg[TREE - 1];

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt_reg <= 8'h00;
            tree_reg <= 8'h00;
        end
        else
        begin
            cnt_reg <= cnt_reg + 8'h01;
            tree_reg <= {tree_reg[6:0], fb_tap};
        end
    end
endmodule

// ==== cpc_pkg.sv ====
/*
 * Types of the corner clock generator PLL controller.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cpc_pkg;

    typedef enum logic [1:0] {
        CPC_OP_NORMAL,
        CPC_OP_BYPASS,
        CPC_OP_PWRDN,
        CPC_OP_RESET
    } cpc_op_t;

    typedef enum logic [1:0] {
        CPC_FB_INTERNAL,
        CPC_FB_EXTERNAL,
        CPC_FB_MIXED,
        CPC_FB_UNUSED
    } cpc_fbm_t;

endpackage

// ==== tb_top.sv ====
/* Self-checking bench of cpc_corner_pll with its fabric partner.
 * Assumes the checker is bound from its own file. */
`timescale 1ns/100ps
module tb_top;
    logic         core_clk, reset_n, reg_wr, reg_rd, fb_ext_in, fb_tap;
    logic         pin_ctrl_sel, pin_frac_en, pin_div2, pin_phase_reset;
    logic         ref_div_clk, pfd_fb_clk, pll_lock, cfg_err;
    logic [1:0]   pin_op_mode, pin_fb_mode, pin_fb_out_sel;
    logic [3:0]   pin_ref_sel, pin_out_bypass, prev_pll_out, pll_out;
    logic [5:0]   pin_ref_div, ref_buf_in;
    logic [7:0]   reg_addr, pin_fb_div;
    logic [11:0]  pin_out_phase;
    logic [15:0]  pin_frac, fabric_clk_data;
    logic [23:0]  pin_out_div;
    logic [31:0]  reg_wdata, reg_rdata, top_bus, bot_bus, seed;
    logic [47:0]  global_bus;
    logic [127:0] top_src, bot_src;
    int           fails, n_tests, i, j, k, s;

    cpc_corner_pll #(.LOCK_INT_REFS(4), .LOCK_FRAC_REFS(4)) uut (.*);
    cpc_fabric_model fab (.*);

    initial core_clk = 1'b0;
    always #5 core_clk = ~core_clk;

    task automatic end_sim;
        if (fails == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                          input logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
        check(reg_rdata & m, e);
    endtask

    task automatic wait_lock(input int lim);
        int t;
        for (t = 0; t < lim && pll_lock !== 1'b1; t++)
            @(posedge core_clk);
        check(pll_lock, 1'b1);
        if (t == lim)
            end_sim();
    endtask

    function automatic logic hub_exp(input int sel, input int src);
        if (sel < 32)
            return top_src[src];
        if (sel < 64)
            return bot_src[src];
        if (sel < 80)
            return fabric_clk_data[sel - 64];
        return 1'b0;
    endfunction

    initial
    begin
        seed = 32'hE995D73A;
        fails = 0;
        n_tests = 0;
        {reset_n, reg_wr, reg_rd, pin_ctrl_sel, pin_frac_en} = 5'h00;
        {pin_div2, pin_phase_reset, pin_op_mode, pin_fb_mode} = 6'h00;
        {pin_fb_out_sel, pin_ref_sel, pin_out_bypass} = 10'h000;
        {reg_addr, reg_wdata, pin_frac, pin_out_phase} = '0;
        {top_src, bot_src, fabric_clk_data} = '0;
        pin_ref_div = 6'h01;
        pin_fb_div = 8'h02;
        pin_out_div = {4{6'h01}};
        repeat (20) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        rd_chk(8'h00, 32'hFFFFFFFF, 32'h3);
        rd_chk(8'h02, 32'hFFFFFFFF, 32'h2);
        rd_chk(8'h04, 32'hFFFFFFFF, 32'h1);
        rd_chk(8'h03, 32'hFFFFFFFF, 32'h0);
        wr(8'h08, 32'hFFFFFFFF);
        rd_chk(8'h08, 32'hFFFFFFFF, 32'h0);
        wr(8'h01, 32'h00000100);
        wr(8'h00, 32'h0);
        wait_lock(40);
        wr(8'h00, 32'h20);
        repeat (2) @(posedge core_clk);
        check(pll_lock, 1'b0);
        wait_lock(40);
        wr(8'h02, 32'h3);
        repeat (2) @(posedge core_clk);
        check(pll_lock, 1'b0);
        wait_lock(40);
        wr(8'h04, 32'h0);
        repeat (3) @(posedge core_clk);
        rd_chk(8'h08, 32'h3, 32'h2);
        wr(8'h04, 32'h301);
        repeat (150) @(posedge core_clk);
        rd_chk(8'h08, 32'h700, 32'h300);
        wr(8'h00, 32'h60);
        rd_chk(8'h08, 32'h700, 32'h0);
        for (i = 0; i < 8; i++)
        begin
            j = $random(seed) & 31;
            s = $random(seed) & 127;
            k = (i % 4 == 3) ? 80 + i : (i % 4) * 32 + (j & 31);
            if (i % 4 == 2)
                k = 64 + (j & 15);
            wr(8'(64 + j), 32'(s));
            wr(8'(96 + j), 32'(s));
            wr(8'(128 + j), 32'(k));
            top_src <= {$random(seed), $random(seed), $random(seed), 32'h0};
            bot_src <= {$random(seed), $random(seed), $random(seed), 32'h1};
            fabric_clk_data <= 16'($random(seed));
            repeat (3) @(posedge core_clk);
            check(top_bus[j], top_src[s]);
            check(bot_bus[j], bot_src[s]);
            check(global_bus[j], hub_exp(k, s));
        end
        pin_ctrl_sel <= 1'b1;
        pin_op_mode <= 2'h1;
        pin_out_bypass <= 4'h2;
        repeat (6) @(posedge core_clk);
        check(pll_out[0], !ref_buf_in[0]);
        rd_chk(8'h08, 32'h4, 32'h4);
        pin_op_mode <= 2'h0;
        pin_fb_mode <= 2'h1;
        // Feedback output keeps its phase; out1 rotates instead
        pin_out_phase <= 12'h028;
        wait_lock(60);
        pin_ref_div <= 6'h02;
        pin_fb_div <= 8'h03;
        repeat (2) @(posedge core_clk);
        check(pll_lock, 1'b0);
        k = ref_div_clk;
        repeat (2) @(posedge core_clk);
        check(ref_div_clk, !k[0]);
        pin_fb_mode <= 2'h2;
        pin_frac_en <= 1'b1;
        repeat (2) @(posedge core_clk);
        check(cfg_err, 1'b1);
        pin_phase_reset <= 1'b1;
        pin_op_mode <= 2'h3;
        repeat (4) @(posedge core_clk);
        check(pll_out, 4'h0);
        end_sim();
    end
endmodule
